// file: dac_pkg.sv
// Purpose: Shared constants and types for the display attribute control block.
// Assumes: Registers reached through the documented parallel port pins only.
// Notes: Offsets are the port's own register-select codes.
//
// Notes on behaviour
// - Port uses 8-bit data, read/write, three chip select inputs, two register selects.
// - Port timed by processor phase-two enable and cleared by general reset.
// - Control A bit 7 enables field attribute decoding; code FF decoded whatever bit 7 holds.
// - Control A bit 6 holds the timing controller in reset when set.
// - Control A bit 4 selects covering or transparent cursor form.
// - Control B bit 7 stops attribute wrap from last text line to first.
// - Control B bit 6 selects 12-location or 16-location glyph mode.
// - Control B bit 4 clear blocks video to the tube unit.
// - Control B bit 2 makes the base colour flag effective when set.
// - Control B bit 0 ends attribute validity at line end when set.
// - Decoder classifies each memory code as character or field attribute.
// - Code FF while presentation active raises message-line detect, latched as flag.
// - Video-off detect on bit 6 low and bits 3-2 high, latched from attributes.
// - Message-line loads clock the attribute register without capturing video-off.
// - Field and extended attribute registers load on attribute-register clock.
// - Attribute-register clock also pulses at horizontal sync outside glyph loading.
// - Presentation active follows display enable and gates attribute recognition.
package dac_pkg;
  // ==========================================================
  // Port register selects {rs1, rs0}; control bit 2 picks data or direction.
  localparam logic [1:0] DAC_RS_A = 2'h0;
  localparam logic [1:0] DAC_RS_CA = 2'h1;
  localparam logic [1:0] DAC_RS_B = 2'h2;
  localparam logic [1:0] DAC_RS_CB = 2'h3;
  localparam int DAC_CR_DDR_SEL_BIT = 2;
  localparam logic [7:0] DAC_CR_RST = 8'h00;
  localparam logic [7:0] DAC_OUT_RST = 8'h00;
  localparam logic [7:0] DAC_DDR_RST = 8'h00;
  localparam logic [7:0] DAC_MLA_CODE = 8'hff;
  // ==========================================================
  // Field positions.
  localparam int DAC_A_FA_EN = 7;
  localparam int DAC_A_TC_RST = 6;
  localparam int DAC_A_CUR = 4;
  localparam int DAC_B_PAGE_STOP = 7;
  localparam int DAC_B_GLYPH = 6;
  localparam int DAC_B_VIDEO = 4;
  localparam int DAC_B_BASE = 2;
  localparam int DAC_B_LINE_STOP = 0;

  typedef struct packed {
    logic field_attr_interp_enable;
    logic timing_ctrl_reset;
    logic cursor_shape_select;
    logic page_end_stop;
    logic glyph_height_select;
    logic video_pass_enable;
    logic base_colour_effective;
    logic line_end_stop;
  } dac_ctrl_t;

  typedef struct packed {
    logic message_line_flag;
    logic video_off_flag;
    logic fa5;
    logic fa3;
  } dac_fa_t;
endpackage

// file: dac_top.sv
// Purpose: Parallel control port plus field attribute decoder and registers.
// Assumes: Phase-two enable, sync and display enable are external pins.
// Notes: The port's strobe is the synchronised phase-two level's falling edge.
module dac_top (
  input wire logic mclk_i, // 40 MHz clock
  input wire logic rst_n_i, // general reset, active low
  input wire logic phi2_i, // processor phase-two enable pin
  input wire logic cs_addr3_i, // address bit 3 chip select
  input wire logic [1:0] decoder_chip_selects_i, // from address decoder
  input wire logic [1:0] rs_i, // register select, address bits 1..0
  input wire logic rw_i, // 1 read, 0 write
  input wire logic [7:0] data_i, // data bus in
  output logic [7:0] data_o, // data bus out
  output logic data_oe_o, // data bus drive enable
  input wire logic [7:0] display_memory_code_i, // code from display memory
  input wire logic [7:0] ext_attr_i, // extended attribute byte
  input wire logic hsync_i, // horizontal sync pin
  input wire logic display_enable_out_i, // timing controller enable pin
  input wire logic glyph_store_load_i, // character generator loading
  output dac_pkg::dac_ctrl_t ctrl_o, // presentation settings
  output logic presentation_active_o, // registered display enable
  output logic message_line_detect_o, // code FF seen, active
  output logic video_off_detect_o, // video-off code pattern
  output logic attribute_register_clock_o, // attribute load strobe
  output dac_pkg::dac_fa_t fa_o, // field attribute register
  output logic [7:0] efa_o, // extended field attribute register
  output logic video_blank_o // video blocked
);
  import dac_pkg::*;

  // ==========================================================
  // Pin synchronisers.
  // The bus pins follow the processor's own timing, so they pass two flip-flops
  // just like phase two; the strobe then sees selects and data of the same age.
  // The cost is two clocks of latency, which the long phase-two level easily covers.
  logic [1:0] phi2_s_q, hs_s_q, de_s_q, ld_s_q;
  logic [1:0] cs_s_q, rw_s_q;
  logic [1:0][1:0] dcs_s_q, rs_s_q;
  logic [1:0][7:0] wd_s_q;
  logic phi2_d_q;
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      phi2_s_q <= 2'h0;
      hs_s_q <= 2'h0;
      de_s_q <= 2'h0;
      ld_s_q <= 2'h0;
      cs_s_q <= 2'h0;
      rw_s_q <= 2'h0;
      dcs_s_q <= 4'h0;
      rs_s_q <= 4'h0;
      wd_s_q <= 16'h0000;
      phi2_d_q <= 1'b0;
    end else begin
      phi2_s_q <= {phi2_s_q[0], phi2_i};
      hs_s_q <= {hs_s_q[0], hsync_i};
      de_s_q <= {de_s_q[0], display_enable_out_i};
      ld_s_q <= {ld_s_q[0], glyph_store_load_i};
      cs_s_q <= {cs_s_q[0], cs_addr3_i};
      rw_s_q <= {rw_s_q[0], rw_i};
      dcs_s_q <= {dcs_s_q[0], decoder_chip_selects_i};
      rs_s_q <= {rs_s_q[0], rs_i};
      wd_s_q <= {wd_s_q[0], data_i};
      phi2_d_q <= phi2_s_q[1];
    end
  end
  wire phi2 = phi2_s_q[1];
  wire hs = hs_s_q[1];
  wire ld = ld_s_q[1];
  wire cs_s = cs_s_q[1];
  wire rw_s = rw_s_q[1];
  wire [1:0] dcs_s = dcs_s_q[1];
  wire [1:0] rs_s = rs_s_q[1];
  wire [7:0] wd_s = wd_s_q[1];

  // ==========================================================
  // Port registers.
  logic [7:0] out_a_q, out_b_q, ddr_a_q, ddr_b_q, cr_a_q, cr_b_q;
  wire sel = cs_s & dcs_s[0] & ~dcs_s[1];
  wire strobe = phi2_d_q & ~phi2 & sel;
  wire wr = strobe & ~rw_s;
  wire wr_a = wr && rs_s == DAC_RS_A;
  wire wr_b = wr && rs_s == DAC_RS_B;
  wire wr_ca = wr && rs_s == DAC_RS_CA;
  wire wr_cb = wr && rs_s == DAC_RS_CB;
  wire a_data = cr_a_q[DAC_CR_DDR_SEL_BIT];
  wire b_data = cr_b_q[DAC_CR_DDR_SEL_BIT];

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      out_a_q <= DAC_OUT_RST;
      out_b_q <= DAC_OUT_RST;
      ddr_a_q <= DAC_DDR_RST;
      ddr_b_q <= DAC_DDR_RST;
      cr_a_q <= DAC_CR_RST;
      cr_b_q <= DAC_CR_RST;
    end else begin
      if (wr_a && a_data) out_a_q <= wd_s;
      if (wr_a && !a_data) ddr_a_q <= wd_s;
      if (wr_b && b_data) out_b_q <= wd_s;
      if (wr_b && !b_data) ddr_b_q <= wd_s;
      if (wr_ca) cr_a_q <= wd_s;
      if (wr_cb) cr_b_q <= wd_s;
    end
  end

  wire [7:0] pa = out_a_q & ddr_a_q;
  wire [7:0] pb = out_b_q & ddr_b_q;
  wire [7:0] rd_a = a_data ? pa : ddr_a_q;
  wire [7:0] rd_b = b_data ? pb : ddr_b_q;
  wire [7:0] rd_mux = (rs_s == DAC_RS_A) ? rd_a :
                      (rs_s == DAC_RS_B) ? rd_b :
                      (rs_s == DAC_RS_CA) ? cr_a_q : cr_b_q;
  assign data_o = rd_mux;
  assign data_oe_o = sel & rw_s & phi2;

  assign ctrl_o.field_attr_interp_enable = pa[DAC_A_FA_EN];
  assign ctrl_o.timing_ctrl_reset = pa[DAC_A_TC_RST];
  assign ctrl_o.cursor_shape_select = pa[DAC_A_CUR];
  assign ctrl_o.page_end_stop = pb[DAC_B_PAGE_STOP];
  assign ctrl_o.glyph_height_select = pb[DAC_B_GLYPH];
  assign ctrl_o.video_pass_enable = pb[DAC_B_VIDEO];
  assign ctrl_o.base_colour_effective = pb[DAC_B_BASE];
  assign ctrl_o.line_end_stop = pb[DAC_B_LINE_STOP];

  // ==========================================================
  // Field attribute decoder.
  logic dmg_q;
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) dmg_q <= 1'b0;
    else dmg_q <= de_s_q[1];
  end
  assign presentation_active_o = dmg_q;

  wire [7:0] ch = display_memory_code_i;
  dac_fa_t fa_q;
  logic [7:0] efa_q;
  wire is_mla = (ch == DAC_MLA_CODE);
  wire is_fa = ch[7] & ~ch[6];
  assign message_line_detect_o = is_mla & dmg_q;
  assign video_off_detect_o = ~ch[6] & ch[3] & ch[2];
  wire no_msg = ~fa_q.message_line_flag;
  wire fa_load = ~ld & dmg_q & no_msg &
                 ((ctrl_o.field_attr_interp_enable & is_fa) | is_mla);
  wire hs_load = ~ld & hs;
  assign attribute_register_clock_o = fa_load | hs_load;

  // Sync loads clear the registers; the wrap memory lives elsewhere.
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fa_q <= '0;
      efa_q <= 8'h00;
    end else if (hs_load) begin
      fa_q <= '0;
      efa_q <= 8'h00;
    end else if (fa_load) begin
      fa_q <= '{message_line_detect_o, video_off_detect_o, ch[5], ch[3]};
      efa_q <= ext_attr_i;
    end
  end
  assign fa_o = fa_q;
  assign efa_o = efa_q;
  assign video_blank_o = fa_q.video_off_flag | ~ctrl_o.video_pass_enable;

  // ==========================================================
  // Checks.
  ml_flag_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    fa_load && !hs_load && is_mla |=> fa_q.message_line_flag && !fa_q.video_off_flag)
    else $error("message line load wrong");
  vo_latch_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    fa_load && !hs_load && is_fa && ch[3] && ch[2] |=> fa_q.video_off_flag)
    else $error("video off not latched");
  fa_gate_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    is_fa && !is_mla && !ctrl_o.field_attr_interp_enable && !hs |-> !fa_load)
    else $error("attribute taken while disabled");
  hs_clk_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    hs && !ld |-> attribute_register_clock_o)
    else $error("sync load missing");
  dmg_gate_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    !dmg_q |-> !message_line_detect_o && !fa_load)
    else $error("recognised while inactive");
  dmg_follow_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    $rose(de_s_q[1]) |=> dmg_q)
    else $error("presentation active late");
  wr_a_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    wr_a && a_data |=> out_a_q == $past(wd_s))
    else $error("port A write lost");
  video_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    !ctrl_o.video_pass_enable |-> video_blank_o)
    else $error("video not blocked");
  ctrl_b_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    ctrl_o.line_end_stop == (out_b_q[0] & ddr_b_q[0]))
    else $error("line stop mismatch");
  ml_c: cover property (@(posedge mclk_i) disable iff (!rst_n_i) fa_load && is_mla);
  vo_c: cover property (@(posedge mclk_i) disable iff (!rst_n_i) fa_q.video_off_flag);
  hs_c: cover property (@(posedge mclk_i) disable iff (!rst_n_i) hs_load);
  wr_c: cover property (@(posedge mclk_i) disable iff (!rst_n_i) wr_a && a_data);
  ld_c: cover property (@(posedge mclk_i) disable iff (!rst_n_i) ld && hs);

  // ==========================================================
  // Port checks.
  // Each setting must follow the written bit once its line is an output.
  fa_en_bit_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    wr_a && a_data && ddr_a_q[DAC_A_FA_EN] |=>
    ctrl_o.field_attr_interp_enable == $past(wd_s[DAC_A_FA_EN]))
    else $error("interpretation enable not set");
  tc_rst_bit_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    wr_a && a_data && ddr_a_q[DAC_A_TC_RST] |=>
    ctrl_o.timing_ctrl_reset == $past(wd_s[DAC_A_TC_RST]))
    else $error("controller reset not set");
  cursor_bit_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    wr_a && a_data && ddr_a_q[DAC_A_CUR] |=>
    ctrl_o.cursor_shape_select == $past(wd_s[DAC_A_CUR]))
    else $error("cursor form not set");
  page_bit_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    wr_b && b_data && ddr_b_q[DAC_B_PAGE_STOP] |=>
    ctrl_o.page_end_stop == $past(wd_s[DAC_B_PAGE_STOP]))
    else $error("page stop not set");
  glyph_bit_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    wr_b && b_data && ddr_b_q[DAC_B_GLYPH] |=>
    ctrl_o.glyph_height_select == $past(wd_s[DAC_B_GLYPH]))
    else $error("glyph mode not set");
  video_bit_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    wr_b && b_data && ddr_b_q[DAC_B_VIDEO] |=>
    ctrl_o.video_pass_enable == $past(wd_s[DAC_B_VIDEO]))
    else $error("video pass not set");
  base_bit_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    wr_b && b_data && ddr_b_q[DAC_B_BASE] |=>
    ctrl_o.base_colour_effective == $past(wd_s[DAC_B_BASE]))
    else $error("base colour not set");
  line_bit_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    wr_b && b_data && ddr_b_q[DAC_B_LINE_STOP] |=>
    ctrl_o.line_end_stop == $past(wd_s[DAC_B_LINE_STOP]))
    else $error("line stop not set");

  // A deselected port must keep the data and control registers untouched.
  unsel_hold_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    !sel |=> $stable(out_a_q) && $stable(out_b_q) && $stable(cr_a_q) && $stable(cr_b_q))
    else $error("write while deselected");
  oe_sel_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    data_oe_o |-> sel && rw_s)
    else $error("bus driven without read");
  strobe_one_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    strobe |=> !strobe)
    else $error("strobe longer than one clock");
  wr_b_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    wr_b && b_data |=> out_b_q == $past(wd_s))
    else $error("port B write lost");
  cr_a_wr_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    wr_ca |=> cr_a_q == $past(wd_s))
    else $error("control A write lost");
  cr_b_wr_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    wr_cb |=> cr_b_q == $past(wd_s))
    else $error("control B write lost");
  ddr_a_wr_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    wr_a && !a_data |=> ddr_a_q == $past(wd_s))
    else $error("direction A write lost");
  ddr_b_wr_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    wr_b && !b_data |=> ddr_b_q == $past(wd_s))
    else $error("direction B write lost");

  // ==========================================================
  // Decoder checks.
  // Sync clears win over attribute loads, so these look at attribute loads alone.
  class_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    fa_load |-> is_fa || is_mla)
    else $error("character code loaded");
  ml_level_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    message_line_detect_o |-> dmg_q && is_mla)
    else $error("message detect without code");
  ml_hold_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    fa_q.message_line_flag && !hs_load |=> fa_q.message_line_flag)
    else $error("message flag dropped");
  vo_blank_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    fa_q.video_off_flag |-> video_blank_o)
    else $error("video off flag ignored");
  ml_no_vo_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    is_mla |-> !video_off_detect_o)
    else $error("video off on message code");
  efa_load_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    fa_load && !hs_load |=> efa_q == $past(ext_attr_i))
    else $error("extended attribute not loaded");
  fa_bits_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    fa_load && !hs_load |=> fa_q.fa5 == $past(ch[5]) && fa_q.fa3 == $past(ch[3]))
    else $error("attribute bits not loaded");
  hs_clear_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    hs_load |=> fa_q == '0 && efa_q == 8'h00)
    else $error("sync load did not clear");
  ld_block_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    ld |-> !attribute_register_clock_o)
    else $error("load during glyph loading");
  dmg_fall_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    $fell(de_s_q[1]) |=> !dmg_q)
    else $error("presentation active stuck");
endmodule // dac_top

// file: dac_bus_model.sv
// Purpose: Processor bus master and address decoder model for the port.
// Assumes: One access per phase-two cycle, four clocks high and five low between back-to-back accesses.
// Notes: Idle write data shows the inverse of the last value.
module dac_bus_model (
  input wire logic mclk_i, // clock
  input wire logic [7:0] rd_i, // port read data
  input wire logic oe_i, // port drive enable
  output logic phi2_o, // phase-two enable
  output logic cs_o, // address bit 3 select
  output logic [1:0] dcs_o, // decoder selects
  output logic [1:0] rs_o, // register select
  output logic rw_o, // 1 read, 0 write
  output logic [7:0] wd_o // write data
);
  initial begin
    {phi2_o, cs_o, dcs_o, rs_o, rw_o, wd_o} = {1'b0, 1'b0, 2'h2, 2'h0, 1'b1, 8'h00};
  end
  // ==========================================================
  // bus cycle
  // Selects and data stand through the whole phase so the late sampled strobe sees them.
  task automatic access(input logic sel, input logic rw, input logic [1:0] rs,
      input logic [7:0] d, output logic [7:0] q);
    @(posedge mclk_i);
    {phi2_o, cs_o, dcs_o, rs_o, rw_o, wd_o} <= {1'b1, sel, ~sel, sel, rs, rw, d};
    repeat (4) @(posedge mclk_i);
    // An undriven bus reads back inverted, so a missing drive enable shows up.
    q = oe_i ? rd_i : ~rd_i;
    phi2_o <= 1'b0;
    repeat (4) @(posedge mclk_i);
    {cs_o, dcs_o, rw_o, wd_o} <= {1'b0, 2'h2, 1'b1, ~d};
  endtask
endmodule // dac_bus_model

// file: testbench.sv
// Purpose: Self-checking bench for the display attribute control block.
// Assumes: Port reached only through the bus model's cycles.
// Notes: Presentation pins are driven directly by the bench.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import dac_pkg::*;
  logic mclk, rst_n, phi2, cs, rw, hs, de, gl, oe, mld, vod, arc, pa, blank;
  logic [1:0] dcs, rs;
  logic [7:0] wd, rd, code, ext, efa, q;
  dac_ctrl_t ctrl;
  dac_fa_t fa;
  int failures, num_checks;
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  dac_bus_model bus_u (.mclk_i(mclk), .rd_i(rd), .oe_i(oe), .phi2_o(phi2), .cs_o(cs), .dcs_o(dcs),
    .rs_o(rs), .rw_o(rw), .wd_o(wd));
  dac_top dut_u (.mclk_i(mclk), .rst_n_i(rst_n), .phi2_i(phi2), .cs_addr3_i(cs),
    .decoder_chip_selects_i(dcs), .rs_i(rs), .rw_i(rw), .data_i(wd), .data_o(rd),
    .data_oe_o(oe), .display_memory_code_i(code), .ext_attr_i(ext), .hsync_i(hs),
    .display_enable_out_i(de), .glyph_store_load_i(gl), .ctrl_o(ctrl),
    .presentation_active_o(pa), .message_line_detect_o(mld), .video_off_detect_o(vod),
    .attribute_register_clock_o(arc), .fa_o(fa), .efa_o(efa), .video_blank_o(blank));
  // ==========================================================
  // Helpers
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic test_done;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic wr(input logic [1:0] r, input logic [7:0] d);
    bus_u.access(1'b1, 1'b0, r, d, q);
  endtask
  task automatic step(input logic [7:0] c, input logic [7:0] e, input logic ld,
      input logic [3:0] fe, input logic [7:0] ee);
    @(posedge mclk);
    code <= c;
    ext <= e;
    @(negedge mclk);
    chk("detect", {6'h0, (c == 8'hff) & de, ~c[6] & (c[3:2] == 2'h3)}, {6'h0, mld, vod});
    chk("arclk", {7'h0, ld}, {7'h0, arc});
    @(posedge mclk);
    code <= 8'h00;
    @(negedge mclk);
    chk("fa", {4'h0, fe}, {4'h0, fa});
    chk("efa", ee, efa);
  endtask
  task automatic pulse_hs;
    @(posedge mclk);
    hs <= 1'b1;
    repeat (4) @(posedge mclk);
    @(negedge mclk);
    chk("arclk", 8'h01, {7'h0, arc});
    @(posedge mclk);
    hs <= 1'b0;
    repeat (4) @(posedge mclk);
    @(negedge mclk);
    chk("fa", 8'h00, {4'h0, fa});
    chk("blank", 8'h00, {7'h0, blank});
  endtask
  // ==========================================================
  // Scenarios
  task automatic test_reset;
    chk("ctrl", 8'h00, ctrl);
    chk("blank", 8'h01, {7'h0, blank});
  endtask
  task automatic test_port;
    wr(DAC_RS_A, 8'hff);
    wr(DAC_RS_CA, 8'h04);
    wr(DAC_RS_A, 8'h90);
    wr(DAC_RS_CB, 8'h04);
    wr(DAC_RS_B, 8'h45);
    chk("ctrl", 8'ha0, ctrl);
    wr(DAC_RS_CB, 8'h00);
    wr(DAC_RS_B, 8'hff);
    wr(DAC_RS_CB, 8'h04);
    chk("ctrl", 8'hab, ctrl);
    chk("blank", 8'h01, {7'h0, blank});
    wr(DAC_RS_B, 8'h95);
    bus_u.access(1'b0, 1'b0, DAC_RS_A, 8'h40, q);
    chk("ctrl", 8'hb7, ctrl);
    wr(DAC_RS_A, 8'h40);
    chk("ctrl", 8'h57, ctrl);
    bus_u.access(1'b1, 1'b1, DAC_RS_A, 8'h00, q);
    chk("read", 8'h40, q);
  endtask
  task automatic test_attr;
    de <= 1'b1;
    repeat (6) @(posedge mclk);
    step(8'h8c, 8'h5a, 1'b0, 4'h0, 8'h00);
    wr(DAC_RS_A, 8'h90);
    step(8'h8c, 8'h5a, 1'b1, 4'h5, 8'h5a);
    chk("blank", 8'h01, {7'h0, blank});
    pulse_hs();
    step(8'hff, 8'h3c, 1'b1, 4'hb, 8'h3c);
    step(8'ha0, 8'h11, 1'b0, 4'hb, 8'h3c);
    pulse_hs();
    @(posedge mclk);
    gl <= 1'b1;
    repeat (3) @(posedge mclk);
    step(8'hff, 8'h3c, 1'b0, 4'h0, 8'h00);
    @(posedge mclk);
    gl <= 1'b0;
    de <= 1'b0;
    repeat (6) @(posedge mclk);
    step(8'hff, 8'h3c, 1'b0, 4'h0, 8'h00);
  endtask
  initial begin
    {rst_n, hs, de, gl, code, ext} = {1'b0, 1'b0, 1'b0, 1'b0, 8'h00, 8'h00};
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (4) @(posedge mclk);
    test_reset();
    test_port();
    test_attr();
    test_done();
  end
  initial begin
    #50000;
    failures++;
    test_done();
  end
endmodule // testbench
